// >>> rtl/cfat_cmd_engine.sv
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/10ps
module cfat_cmd_engine (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Register port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wrData,
   input  wire logic        wrStb,
   input  wire logic        rdStb,
   output logic      [31:0] rdData,
   // Completion
   output logic             cmdDone
);
   cfat_pkg::cfat_state_type stateReg;
   cfat_pkg::cfat_cmd_type   cmdReg;
   logic [7:0]  p1Reg, p2Reg;
   logic [8:0]  lcReg, leReg;
   logic [7:0]  dataMem [16], respMem [16];
   logic [7:0]  dataCnt, respLen, rdPtr;
   logic [31:0] keyReg;
   logic [63:0] ublkCode, pinCode;
   logic [3:0]  ublkTries, pinTries;
   logic        pinEn, pendReg;
   logic [7:0]  fileOff;
   logic [15:0] accReg;
   logic [2:0]  selReg, target;
   logic [15:0] swReg, swNext;
   logic [63:0] firstCode, secondCode;
   logic [3:0]  lastIdx;
   logic        isExec, issue, lcHas, leHas, lenMatch;
   logic        paramBad, lenBad, bad, match;
   logic [7:0]  lcVal;

   assign isExec = (stateReg == cfat_pkg::ST_EXEC);
   assign issue  = wrStb && (addr == cfat_pkg::A_CMD);
   assign lcHas  = lcReg[cfat_pkg::LEN_HAS];
   assign leHas  = leReg[cfat_pkg::LEN_HAS];
   assign lcVal  = lcReg[7:0];
   assign lenMatch = lcHas ? (dataCnt == lcVal) : (dataCnt == 8'h00);
   assign lastIdx = (dataCnt > cfat_pkg::BUF_DEPTH) ? 4'hF
                                                    : 4'(dataCnt - 8'h01);
   // A file id or path names its file by the last byte held in the buffer (the sixteenth when more are sent).
   assign target = (dataCnt != 8'h00) ? dataMem[lastIdx][2:0] : selReg;
   assign bad = paramBad || lenBad;
   assign match = (firstCode == ublkCode);

   genvar g;
   generate
      for (g = 0; g < cfat_pkg::CODE_BYTES; g++) begin : g_pack
         assign firstCode[8*g +: 8]  = dataMem[g];
         assign secondCode[8*g +: 8] = dataMem[g + cfat_pkg::CODE_BYTES];
      end
   endgenerate

   // Parameter and length screening for each command except C_SELECT and C_FILEOP.
   always_comb begin
      paramBad = 1'b0;
      lenBad   = 1'b0;
      unique case (cmdReg)
         cfat_pkg::C_UNBLOCK: begin
            paramBad = (p1Reg != cfat_pkg::ZERO_B);
            lenBad = leHas || !lcHas || !lenMatch
                     || (lcVal != cfat_pkg::ZERO_B
                         && lcVal != cfat_pkg::UNBLOCK_LC);
         end
         cfat_pkg::C_DISABLE, cfat_pkg::C_ENABLE: begin
            paramBad = (p2Reg != cfat_pkg::ZERO_B);
            lenBad = leHas || !lenMatch;
         end
         cfat_pkg::C_AUTH: begin
            paramBad = (p1Reg != cfat_pkg::ZERO_B)
               || (p2Reg[cfat_pkg::P2_RFU_HI:cfat_pkg::P2_RFU_LO] != 2'h0)
               || (p2Reg != cfat_pkg::ZERO_B
                   && p2Reg[cfat_pkg::P2_REF_HI:0] == 5'h00);
            lenBad = !lcHas || !leHas || !lenMatch
                     || lcVal > cfat_pkg::BUF_DEPTH;
         end
         cfat_pkg::C_PROFILE, cfat_pkg::C_UPLOAD, cfat_pkg::C_FETCH: begin
            paramBad = (p1Reg != cfat_pkg::ZERO_B)
                       || (p2Reg != cfat_pkg::ZERO_B);
            if (cmdReg == cfat_pkg::C_PROFILE)
               lenBad = !lcHas || leHas || !lenMatch;
            else if (cmdReg == cfat_pkg::C_UPLOAD)
               lenBad = !lcHas || !lenMatch;
            else
               lenBad = lcHas || !leHas || dataCnt != 8'h00;
         end
         default: ;
      endcase
   end

   // Status word chosen for the command being executed.
   always_comb begin
      swNext = cfat_pkg::SW_OK;
      if (paramBad)
         swNext = cfat_pkg::SW_PARAM;
      else if (lenBad)
         swNext = cfat_pkg::SW_LEN;
      else begin
         unique case (cmdReg)
            cfat_pkg::C_UNBLOCK: begin
               if (lcVal == cfat_pkg::ZERO_B)
                  swNext = {cfat_pkg::SW_RETRY, ublkTries};
               else if (ublkTries == 4'h0)
                  swNext = cfat_pkg::SW_BLOCKED;
               else if (!match)
                  swNext = {cfat_pkg::SW_RETRY, 4'(ublkTries - 4'h1)};
            end
            cfat_pkg::C_DISABLE:
               if (!accReg[target]) swNext = cfat_pkg::SW_SEC;
            cfat_pkg::C_ENABLE:
               if (!accReg[cfat_pkg::NFILES + target])
                  swNext = cfat_pkg::SW_SEC;
            cfat_pkg::C_FETCH:
               if (!pendReg) swNext = cfat_pkg::SW_NODATA;
            cfat_pkg::C_FILEOP:
               if (fileOff[selReg]) swNext = cfat_pkg::SW_COND;
            cfat_pkg::C_AUTH, cfat_pkg::C_PROFILE, cfat_pkg::C_UPLOAD,
            cfat_pkg::C_SELECT: swNext = cfat_pkg::SW_OK;
            default:
               swNext = cfat_pkg::SW_INS;
         endcase
      end
   end

   // Sequencer: a command runs in the cycle after its code is written.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stateReg <= cfat_pkg::ST_IDLE;
      end else begin
         unique case (stateReg)
            cfat_pkg::ST_IDLE: if (issue) stateReg <= cfat_pkg::ST_EXEC;
            cfat_pkg::ST_EXEC: stateReg <= cfat_pkg::ST_IDLE;
         endcase
      end
   end

   // Command header registers written by the terminal side.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmdReg <= cfat_pkg::C_FILEOP;
         p1Reg  <= 8'h00;
         p2Reg  <= 8'h00;
         lcReg  <= 9'h000;
         leReg  <= 9'h000;
         keyReg <= 32'h00000000;
         accReg <= 16'h0000;
      end else if (wrStb) begin
         if (issue) cmdReg <= cfat_pkg::cfat_cmd_type'(wrData[3:0]);
         if (addr == cfat_pkg::A_P1)  p1Reg  <= wrData[7:0];
         if (addr == cfat_pkg::A_P2)  p2Reg  <= wrData[7:0];
         if (addr == cfat_pkg::A_LC)  lcReg  <= wrData[8:0];
         if (addr == cfat_pkg::A_LE)  leReg  <= wrData[8:0];
         if (addr == cfat_pkg::A_KEY) keyReg <= wrData;
         if (addr == cfat_pkg::A_ACC) accReg <= wrData[15:0];
      end
   end

   // Command data buffer; the execution cycle consumes it.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dataCnt <= 8'h00;
      end else if (isExec) begin
         dataCnt <= 8'h00;
      end else if (wrStb && addr == cfat_pkg::A_DATA) begin
         if (dataCnt < cfat_pkg::BUF_DEPTH)
            dataMem[dataCnt[3:0]] <= wrData[7:0];
         if (dataCnt != 8'hFF) dataCnt <= dataCnt + 8'h01;
      end
   end

   // Secret codes, attempt counters and code state.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ublkCode  <= 64'h0000000000000000;
         pinCode   <= 64'h0000000000000000;
         ublkTries <= cfat_pkg::UBLK_INIT;
         pinTries  <= cfat_pkg::PIN_INIT;
         pinEn     <= 1'b1;
      end else if (isExec && cmdReg == cfat_pkg::C_UNBLOCK && !bad
                   && lcVal != cfat_pkg::ZERO_B && ublkTries != 4'h0) begin
         if (match) begin
            pinCode   <= secondCode;
            ublkTries <= cfat_pkg::UBLK_INIT;
            pinTries  <= cfat_pkg::PIN_INIT;
            pinEn     <= 1'b1;
         end else begin
            ublkTries <= ublkTries - 4'h1;
         end
      end else if (wrStb && !isExec) begin
         if (addr == cfat_pkg::A_UBLK_LO) ublkCode[31:0]  <= wrData;
         if (addr == cfat_pkg::A_UBLK_HI) ublkCode[63:32] <= wrData;
      end
   end

   // File status flags and the current selection.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fileOff <= 8'h00;
         selReg  <= 3'h0;
      end else if (isExec && !bad) begin
         if (cmdReg == cfat_pkg::C_DISABLE && accReg[target])
            fileOff[target] <= 1'b1;
         if (cmdReg == cfat_pkg::C_ENABLE
             && accReg[cfat_pkg::NFILES + target])
            fileOff[target] <= 1'b0;
         if (cmdReg == cfat_pkg::C_SELECT) selReg <= target;
      end
   end

   // Pending proactive command; a new posting wins over a pull.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         pendReg <= 1'b0;
      else if (wrStb && addr == cfat_pkg::A_PEND && wrData[0])
         pendReg <= 1'b1;
      else if (isExec && cmdReg == cfat_pkg::C_FETCH && !bad)
         pendReg <= 1'b0;
   end

   // Status word, challenge reply and completion pulse.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         swReg   <= cfat_pkg::SW_RESET;
         respLen <= 8'h00;
         cmdDone <= 1'b0;
      end else begin
         cmdDone <= isExec;
         if (isExec) begin
            swReg <= swNext;
            if (cmdReg == cfat_pkg::C_AUTH && !bad) begin
               respLen <= leReg[7:0];
               for (int i = 0; i < 16; i++)
                  respMem[i] <= dataMem[i] ^ keyReg[8*(i%4) +: 8]
                                ^ p2Reg;
            end
         end
      end
   end

   // Read port; reading the reply register steps through the reply.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdData <= 32'h00000000;
         rdPtr  <= 8'h00;
      end else begin
         rdData <= 32'h00000000;
         if (isExec) rdPtr <= 8'h00;
         if (rdStb) begin
            unique case (addr)
               cfat_pkg::A_P1:      rdData <= {24'h000000, p1Reg};
               cfat_pkg::A_P2:      rdData <= {24'h000000, p2Reg};
               cfat_pkg::A_LC:      rdData <= {23'h000000, lcReg};
               cfat_pkg::A_LE:      rdData <= {23'h000000, leReg};
               cfat_pkg::A_ACC:     rdData <= {16'h0000, accReg};
               cfat_pkg::A_FILE:    rdData <= {21'h000000, selReg, fileOff};
               cfat_pkg::A_PIN_LO:  rdData <= pinCode[31:0];
               cfat_pkg::A_PIN_HI:  rdData <= pinCode[63:32];
               cfat_pkg::A_PEND:    rdData <= {31'h00000000, pendReg};
               cfat_pkg::A_STAT:
                  rdData <= {7'h00, pinEn, pinTries, ublkTries, swReg};
               cfat_pkg::A_RESP: begin
                  if (rdPtr < respLen && rdPtr < cfat_pkg::BUF_DEPTH)
                     rdData <= {24'h000000, respMem[rdPtr[3:0]]};
                  if (!isExec) rdPtr <= rdPtr + 8'h01;
               end
               default:             rdData <= 32'h00000000;
            endcase
         end
      end
   end

   sequence execStep;
      isExec ##1 cmdDone;
   endsequence
   cmd_flow_a: assert property (@(posedge ref_clk) disable iff (rst)
      issue && !isExec |=> execStep) else $error("command not run");
   unblock_p1_a: assert property (@(posedge ref_clk) disable iff (rst)
      isExec && cmdReg == cfat_pkg::C_UNBLOCK && p1Reg != cfat_pkg::ZERO_B
      |=> swReg == cfat_pkg::SW_PARAM) else $error("bad P1 accepted");
   retry_query_a: assert property (@(posedge ref_clk) disable iff (rst)
      isExec && cmdReg == cfat_pkg::C_UNBLOCK && !bad && lcVal == 8'h00
      |=> swReg == {cfat_pkg::SW_RETRY, $past(ublkTries)})
      else $error("retry count wrong");
   unblock_ok_a: assert property (@(posedge ref_clk) disable iff (rst)
      isExec && cmdReg == cfat_pkg::C_UNBLOCK && !bad && match
      && lcVal != 8'h00 && ublkTries != 4'h0
      |=> ublkTries == 4'hA && pinTries == 4'h3 && pinEn
          && pinCode == $past(secondCode)) else $error("unblock failed");
   disable_set_a: assert property (@(posedge ref_clk) disable iff (rst)
      isExec && cmdReg == cfat_pkg::C_DISABLE && !bad && accReg[target]
      |=> fileOff[$past(target)] && swReg == cfat_pkg::SW_OK)
      else $error("file not disabled");
   disable_deny_a: assert property (@(posedge ref_clk) disable iff (rst)
      isExec && cmdReg == cfat_pkg::C_DISABLE && !bad && !accReg[target]
      |=> $stable(fileOff) && swReg == cfat_pkg::SW_SEC)
      else $error("disable without access");
   deact_refuse_a: assert property (@(posedge ref_clk) disable iff (rst)
      isExec && cmdReg == cfat_pkg::C_FILEOP && fileOff[selReg]
      |=> swReg == cfat_pkg::SW_COND) else $error("deactivated file used");
   enable_clr_a: assert property (@(posedge ref_clk) disable iff (rst)
      isExec && cmdReg == cfat_pkg::C_ENABLE && !bad
      && accReg[cfat_pkg::NFILES + target]
      |=> !fileOff[$past(target)]) else $error("file not enabled");
   enable_deny_a: assert property (@(posedge ref_clk) disable iff (rst)
      isExec && cmdReg == cfat_pkg::C_ENABLE && !bad
      && !accReg[cfat_pkg::NFILES + target]
      |=> $stable(fileOff) && swReg == cfat_pkg::SW_SEC)
      else $error("enable without access");
   auth_ref_a: assert property (@(posedge ref_clk) disable iff (rst)
      isExec && cmdReg == cfat_pkg::C_AUTH && p2Reg[6:5] != 2'h0
      |=> swReg == cfat_pkg::SW_PARAM) else $error("bad key ref taken");
   bad_frozen_a: assert property (@(posedge ref_clk) disable iff (rst)
      isExec && bad |=> $stable(fileOff) && $stable(pinCode)
      && $stable(ublkTries) && swReg != cfat_pkg::SW_OK)
      else $error("bad command changed state");
endmodule

// >>> rtl/cfat_pkg.sv
package cfat_pkg;
   localparam int AW = 8;
   localparam int DW = 32;
   // Register byte addresses.
   localparam logic [7:0] A_CMD     = 8'h00;
   localparam logic [7:0] A_P1      = 8'h04;
   localparam logic [7:0] A_P2      = 8'h08;
   localparam logic [7:0] A_LC      = 8'h0C;
   localparam logic [7:0] A_LE      = 8'h10;
   localparam logic [7:0] A_DATA    = 8'h14;
   localparam logic [7:0] A_KEY     = 8'h18;
   localparam logic [7:0] A_RESP    = 8'h1C;
   localparam logic [7:0] A_STAT    = 8'h20;
   localparam logic [7:0] A_ACC     = 8'h24;
   localparam logic [7:0] A_FILE    = 8'h28;
   localparam logic [7:0] A_UBLK_LO = 8'h2C;
   localparam logic [7:0] A_UBLK_HI = 8'h30;
   localparam logic [7:0] A_PIN_LO  = 8'h34;
   localparam logic [7:0] A_PIN_HI  = 8'h38;
   localparam logic [7:0] A_PEND    = 8'h3C;
   // Length registers hold a presence flag above the byte.
   localparam int LEN_HAS = 8;
   localparam logic [7:0] ZERO_B     = 8'h00;
   localparam logic [7:0] UNBLOCK_LC = 8'h10;
   localparam logic [7:0] BUF_DEPTH  = 8'h10;
   localparam int CODE_BYTES = 8;
   localparam int NFILES     = 8;
   localparam logic [3:0] UBLK_INIT = 4'hA;
   localparam logic [3:0] PIN_INIT  = 4'h3;
   // Key reference byte fields.
   localparam int P2_SPEC = 7;
   localparam int P2_RFU_HI = 6;
   localparam int P2_RFU_LO = 5;
   localparam int P2_REF_HI = 4;
   // Status words.
   localparam logic [15:0] SW_OK      = 16'h9000;
   localparam logic [11:0] SW_RETRY   = 12'h63C;
   localparam logic [15:0] SW_LEN     = 16'h6700;
   localparam logic [15:0] SW_PARAM   = 16'h6B00;
   localparam logic [15:0] SW_SEC     = 16'h6982;
   localparam logic [15:0] SW_BLOCKED = 16'h6983;
   localparam logic [15:0] SW_COND    = 16'h6985;
   localparam logic [15:0] SW_NODATA  = 16'h6A88;
   localparam logic [15:0] SW_INS     = 16'h6D00;
   localparam logic [15:0] SW_RESET   = 16'h0000;
   typedef enum logic [3:0] {
      C_UNBLOCK = 4'h1,
      C_DISABLE = 4'h2,
      C_ENABLE  = 4'h3,
      C_AUTH    = 4'h4,
      C_PROFILE = 4'h5,
      C_UPLOAD  = 4'h6,
      C_FETCH   = 4'h7,
      C_SELECT  = 4'h8,
      C_FILEOP  = 4'h9
   } cfat_cmd_type;
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_EXEC = 1'b1
   } cfat_state_type;
endpackage

// >>> tb/cfat_term_model.sv
`timescale 1ns/10ps
module cfat_term_model (
   // Clock
   input  wire logic        ref_clk,
   // Register port toward the card
   output logic      [7:0]  addr,
   output logic      [31:0] wrData,
   output logic             wrStb,
   output logic             rdStb,
   input  wire logic [31:0] rdData
);
   initial begin
      addr = 8'h00;
      wrData = 32'h00000000;
      wrStb = 1'b0;
      rdStb = 1'b0;
   end
   // Released write data is inverted so a stale value is never reused.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge ref_clk);
      wrStb <= 1'b0;
      wrData <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge ref_clk);
      rdStb <= 1'b0;
      #1;
      d = rdData;
   endtask
   // Header first, data bytes in send order, the command code last.
   task automatic send(input logic [3:0] c, input logic [7:0] p1, p2,
                       input logic [8:0] lc, le, input int n,
                       input logic [7:0] b [16]);
      wr(cfat_pkg::A_P1, {24'h000000, p1});
      wr(cfat_pkg::A_P2, {24'h000000, p2});
      wr(cfat_pkg::A_LC, {23'h000000, lc});
      wr(cfat_pkg::A_LE, {23'h000000, le});
      for (int i = 0; i < n; i++) begin
         wr(cfat_pkg::A_DATA, {24'h000000, b[i]});
      end
      wr(cfat_pkg::A_CMD, {28'h0000000, c});
   endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
   localparam logic [8:0] NO = 9'h000;
   logic        ref_clk;
   logic        rst;
   logic [7:0]  addr;
   logic [31:0] wrData;
   logic        wrStb;
   logic        rdStb;
   logic [31:0] rdData;
   logic        cmdDone;
   logic [7:0]  db [16];
   logic [31:0] v;
   int          errCount;
   int          checkCount;
   int          cycles;

   cfat_cmd_engine dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
      .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
      .cmdDone(cmdDone));
   cfat_term_model term (.ref_clk(ref_clk), .addr(addr), .wrData(wrData),
      .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic finalReport();
      if (errCount == 0 && checkCount > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // A hung handshake would otherwise stall the run forever.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         errCount++;
         finalReport();
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, exp);
      checkCount++;
      if (seen !== exp) begin
         errCount++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
      term.rd(a, v);
      check(nm, v, e);
   endtask

   task automatic run(input logic [3:0] c, input logic [7:0] p1, p2,
                      input logic [8:0] lc, le, input int n,
                      input logic [15:0] sw);
      int k;
      term.send(c, p1, p2, lc, le, n, db);
      k = 0;
      while (cmdDone !== 1'b1 && k < 8) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      check("done", {31'h00000000, cmdDone}, 32'h00000001);
      term.rd(cfat_pkg::A_STAT, v);
      check("status", {16'h0000, v[15:0]}, {16'h0000, sw});
   endtask

   task automatic t_unblock();
      for (int i = 0; i < 8; i++) begin
         db[i] = 8'(8'h11 * (i + 1));
         db[8 + i] = 8'(8'hC1 + i);
      end
      term.wr(cfat_pkg::A_UBLK_LO, 32'h44332211);
      term.wr(cfat_pkg::A_UBLK_HI, 32'h88776655);
      run(cfat_pkg::C_UNBLOCK, 8'h01, 8'h00, 9'h100, NO, 0, 16'h6B00);
      run(cfat_pkg::C_UNBLOCK, 8'h00, 8'h00, 9'h108, NO, 8, 16'h6700);
      run(cfat_pkg::C_UNBLOCK, 8'h00, 8'h00, 9'h100, 9'h100, 0,
          16'h6700);
      rdc(cfat_pkg::A_STAT, 32'h013A6700, "tries");
      run(cfat_pkg::C_UNBLOCK, 8'h00, 8'h00, 9'h100, NO, 0, 16'h63CA);
      db[0] = 8'h10;
      run(cfat_pkg::C_UNBLOCK, 8'h00, 8'h00, 9'h110, NO, 16, 16'h63C9);
      run(cfat_pkg::C_UNBLOCK, 8'h00, 8'h00, 9'h100, NO, 0, 16'h63C9);
      db[0] = 8'h11;
      run(cfat_pkg::C_UNBLOCK, 8'h00, 8'h00, 9'h110, NO, 16, 16'h9000);
      rdc(cfat_pkg::A_STAT, 32'h013A9000, "tries");
      rdc(cfat_pkg::A_PIN_LO, 32'hC4C3C2C1, "newLo");
      rdc(cfat_pkg::A_PIN_HI, 32'hC8C7C6C5, "newHi");
   endtask

   task automatic t_files();
      term.wr(cfat_pkg::A_ACC, 32'h00000404);
      db[0] = 8'h03;
      run(cfat_pkg::C_DISABLE, 8'h00, 8'h00, 9'h101, NO, 1, 16'h6982);
      db[0] = 8'h02;
      run(cfat_pkg::C_DISABLE, 8'h08, 8'h00, 9'h101, NO, 1, 16'h9000);
      rdc(cfat_pkg::A_FILE, 32'h00000004, "file");
      run(cfat_pkg::C_SELECT, 8'h00, 8'h00, 9'h101, NO, 1, 16'h9000);
      rdc(cfat_pkg::A_FILE, 32'h00000204, "file");
      run(cfat_pkg::C_FILEOP, 8'h00, 8'h00, 9'h101, NO, 1, 16'h6985);
      run(cfat_pkg::C_ENABLE, 8'h00, 8'h01, 9'h101, NO, 1, 16'h6B00);
      run(cfat_pkg::C_ENABLE, 8'h00, 8'h00, 9'h101, 9'h100, 1,
          16'h6700);
      rdc(cfat_pkg::A_FILE, 32'h00000204, "file");
      run(cfat_pkg::C_ENABLE, 8'h00, 8'h00, NO, NO, 0, 16'h9000);
      rdc(cfat_pkg::A_FILE, 32'h00000200, "file");
      run(cfat_pkg::C_FILEOP, 8'h00, 8'h00, 9'h101, NO, 1, 16'h9000);
      term.wr(cfat_pkg::A_ACC, 32'h00000004);
      run(cfat_pkg::C_DISABLE, 8'h00, 8'h00, 9'h101, NO, 1, 16'h9000);
      run(cfat_pkg::C_ENABLE, 8'h00, 8'h00, 9'h101, NO, 1, 16'h6982);
      rdc(cfat_pkg::A_FILE, 32'h00000204, "file");
   endtask

   task automatic t_auth();
      logic [31:0] key;
      key = 32'h44332211;
      term.wr(cfat_pkg::A_KEY, key);
      for (int i = 0; i < 4; i++) begin
         db[i] = 8'(i + 1);
      end
      run(cfat_pkg::C_AUTH, 8'h00, 8'h81, 9'h104, 9'h104, 4, 16'h9000);
      for (int i = 0; i < 5; i++) begin
         term.rd(cfat_pkg::A_RESP, v);
         check("reply", v, (i < 4) ?
               {24'h000000, db[i] ^ key[8 * i +: 8] ^ 8'h81} :
               32'h00000000);
      end
      run(cfat_pkg::C_AUTH, 8'h01, 8'h81, 9'h104, 9'h104, 4, 16'h6B00);
      run(cfat_pkg::C_AUTH, 8'h00, 8'h41, 9'h104, 9'h104, 4, 16'h6B00);
      run(cfat_pkg::C_AUTH, 8'h00, 8'h21, 9'h104, 9'h104, 4, 16'h6B00);
      run(cfat_pkg::C_AUTH, 8'h00, 8'h80, 9'h104, 9'h104, 4, 16'h6B00);
      run(cfat_pkg::C_AUTH, 8'h00, 8'h1F, 9'h104, 9'h104, 4, 16'h9000);
      run(cfat_pkg::C_AUTH, 8'h00, 8'h00, 9'h104, 9'h104, 4, 16'h9000);
      run(cfat_pkg::C_AUTH, 8'h00, 8'h00, 9'h103, 9'h104, 4, 16'h6700);
   endtask

   task automatic t_toolkit();
      run(cfat_pkg::C_PROFILE, 8'h00, 8'h00, 9'h102, NO, 2, 16'h9000);
      run(cfat_pkg::C_PROFILE, 8'h00, 8'h00, 9'h102, 9'h100, 2,
          16'h6700);
      run(cfat_pkg::C_PROFILE, 8'h01, 8'h00, 9'h102, NO, 2, 16'h6B00);
      run(cfat_pkg::C_UPLOAD, 8'h00, 8'h00, 9'h102, NO, 2, 16'h9000);
      run(cfat_pkg::C_UPLOAD, 8'h00, 8'h00, 9'h102, 9'h110, 2,
          16'h9000);
      run(cfat_pkg::C_UPLOAD, 8'h00, 8'h01, 9'h102, NO, 2, 16'h6B00);
      run(cfat_pkg::C_FETCH, 8'h00, 8'h00, NO, 9'h110, 0, 16'h6A88);
      term.wr(cfat_pkg::A_PEND, 32'h00000001);
      rdc(cfat_pkg::A_PEND, 32'h00000001, "pend");
      run(cfat_pkg::C_FETCH, 8'h00, 8'h00, NO, 9'h110, 0, 16'h9000);
      rdc(cfat_pkg::A_PEND, 32'h00000000, "pend");
      term.wr(cfat_pkg::A_PEND, 32'h00000001);
      run(cfat_pkg::C_FETCH, 8'h00, 8'h00, 9'h100, 9'h110, 0,
          16'h6700);
      rdc(cfat_pkg::A_PEND, 32'h00000001, "pend");
      run(4'hF, 8'h00, 8'h00, NO, NO, 0, 16'h6D00);
      rdc(8'hFC, 32'h00000000, "unmapped");
   endtask

   initial begin
      rst = 1'b1;
      errCount = 0;
      checkCount = 0;
      cycles = 0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rdc(cfat_pkg::A_STAT, 32'h013A0000, "resetStat");
      rdc(cfat_pkg::A_FILE, 32'h00000000, "resetFile");
      t_unblock();
      t_files();
      t_auth();
      t_toolkit();
      finalReport();
   end
endmodule
